// ===== rtl/hptag_defines.svh
// constants of the hashed page table address generator
`ifndef HPTAG_DEFINES_SVH
`define HPTAG_DEFINES_SVH
`define HPTAG_ENTRY32_BYTES 8
`define HPTAG_ENTRY64_BYTES 16
`define HPTAG_GROUP32_BYTES 64
`define HPTAG_SLOTS 8
`define HPTAG_LAST_SLOT 3'h7
`define HPTAG_HASH64_W 39
`define HPTAG_HASH32_W 19
`define HPTAG_PAGE_W 16
`define HPTAG_MASK64_W 28
`define HPTAG_MASK32_W 9
`define HPTAG_SIZE_MAX 5'h1C
`define HPTAG_ORG_W 46
`define HPTAG_SEG_W 52
`define HPTAG_API_W 6
`endif

// ===== rtl/hptag_pkg.sv
// types of the hashed page table address generator
package hptag_pkg;
  // search phase
  typedef enum logic [0:0] {
    PH_IDLE,
    PH_FETCH
  } hptag_phase_t;
endpackage

// ===== rtl/hptag_top.sv
// hashed page table search front end: hash, group address, slot walk
`timescale 1ns/100ps
`default_nettype none
`include "hptag_defines.svh"

// Summary of operation
// R1 - entries are 8 or 16 bytes
// R2 - 32-bit minimum table is 1024 64-byte groups
// R3 - software sizes groups to half the frames
// R4 - two groups, eight slots each
// R5 - primary group first, secondary only on miss
// R6 - secondary miss raises page fault
// R7 - software places entries by same hashes
// R8 - group address from origin and masked hash
// R9 - 64-bit hash: 39 identifier bits xor page
// R10 - secondary hash is complement of primary
// R11 - 32-bit hash: 19 identifier bits xor page
// R12 - software clears origin bits under the mask
// R13 - 32-bit group address layout
// R14 - 64-bit group address layout
// R15 - hit needs valid, matches and hash select
// R16 - size code expands into 28-bit mask
module hptag_top (
  // clock and reset
  input  wire logic                        i_clock,
  input  wire logic                        i_sys_rst,
  // search request
  input  wire logic                        i_req_valid,
  output logic                             o_req_ready,
  input  wire logic                        i_mode64,
  input  wire logic [`HPTAG_SEG_W-1:0]     i_segment_identifier,
  input  wire logic [`HPTAG_PAGE_W-1:0]    i_page_index,
  input  wire logic [`HPTAG_API_W-1:0]     i_abbreviated_page_index,
  // table descriptor fields
  input  wire logic [`HPTAG_ORG_W-1:0]     i_table_origin,
  input  wire logic [`HPTAG_MASK32_W-1:0]  i_table_index_mask,
  input  wire logic [4:0]                  i_table_size_code,
  // table entry read port
  output logic                             o_mem_req,
  output logic [63:0]                      o_mem_addr,
  input  wire logic                        i_mem_ack,
  input  wire logic                        i_ent_valid,
  input  wire logic                        i_ent_hash_sel,
  input  wire logic [`HPTAG_SEG_W-1:0]     i_ent_segment_identifier,
  input  wire logic [`HPTAG_API_W-1:0]     i_ent_abbreviated_page_index,
  // search result
  output logic                             o_done,
  output logic                             o_hit,
  output logic                             o_page_fault,
  output logic [63:0]                      o_entry_addr
);

  // all state of the block except the read count reads_q
  typedef struct packed {
    hptag_pkg::hptag_phase_t             phase;
    logic                                m64;
    logic                                sec;     // secondary group
    logic [2:0]                          slot;
    logic [`HPTAG_SEG_W-1:0]             seg;
    logic [`HPTAG_API_W-1:0]             abbreviated_page_index;
    logic [`HPTAG_ORG_W-1:0]             org;
    logic [`HPTAG_MASK64_W-1:0]          msk;
    logic [`HPTAG_HASH64_W-1:0]          hash;    // primary hash
    logic [63:0]                         addr;
    logic                                done;
    logic                                hit;
    logic                                fault;
    logic [63:0]                         ent_addr;
  } hptag_state_t;

  hptag_state_t s_q;     // registered state
  hptag_state_t s_d;     // next state

  // group address plus slot offset for either model
  function automatic logic [63:0] slot_addr(
    input logic                        m64,
    input logic [`HPTAG_HASH64_W-1:0]  h,
    input logic [`HPTAG_ORG_W-1:0]     org,
    input logic [`HPTAG_MASK64_W-1:0]  msk,
    input logic [2:0]                  slot
  );
    logic [63:0] a;
    a = 64'h0000_0000_0000_0000;
    if (m64) begin
      // origin on top, masked upper hash or-ed in low origin bits [R14]
      a[63:18] = {org[45:28], org[27:0] | (h[38:11] & msk)}; // [R8]
      a[17:7]  = h[10:0];                                    // [R14]
      a[6:4]   = slot;                                       // [R1]
    end else begin
      // only nine origin bits can be overlaid by the hash [R13]
      a[31:25] = org[15:9];
      a[24:16] = org[8:0] | (h[18:10] & msk[8:0]);           // [R8]
      a[15:6]  = h[9:0];                                     // [R13]
      a[5:3]   = slot;                                       // [R1] [R2]
    end
    return a;
  endfunction

  // hash and mask of a fresh request
  logic [`HPTAG_HASH64_W-1:0] req_hash;
  logic [`HPTAG_MASK64_W-1:0] req_msk;
  logic [4:0]                 size_lim;
  logic                       ent_match;
  logic [`HPTAG_HASH64_W-1:0] cur_hash;   // hash of the group in use

  // hash functions and mask expansion
  always_comb begin
    size_lim = (i_table_size_code > `HPTAG_SIZE_MAX) ? `HPTAG_SIZE_MAX
                                                     : i_table_size_code;
    if (i_mode64) begin
      // 39 identifier bits xor zero-extended page index [R9]
      req_hash = i_segment_identifier[38:0] ^ {23'h00_0000, i_page_index};
      // size code, limited to 28, gives the count of low ones in the mask [R16]
      req_msk  = 28'((29'h000_0001 << size_lim) - 29'h000_0001);
    end else begin
      // 19 identifier bits xor page index, upper bits unused [R11]
      req_hash = {20'h0_0000,
                  i_segment_identifier[18:0] ^ {3'h0, i_page_index}};
      req_msk  = {19'h0_0000, i_table_index_mask};
    end
  end

  // secondary hash is the one's complement of the primary [R10]
  assign cur_hash = s_q.sec ? ~s_q.hash : s_q.hash;

  // hit test of the returned entry [R15]
  assign ent_match = i_ent_valid && (i_ent_hash_sel == s_q.sec) &&
                     (i_ent_segment_identifier == s_q.seg) &&
                     (i_ent_abbreviated_page_index == s_q.abbreviated_page_index);

  // next state
  always_comb begin
    s_d       = s_q;
    s_d.done  = 1'b0;
    unique case (s_q.phase)
      hptag_pkg::PH_IDLE: begin
        if (i_req_valid) begin
          // a search always opens on slot 0 of the primary group [R5]
          s_d.phase = hptag_pkg::PH_FETCH;
          s_d.m64   = i_mode64;
          s_d.sec   = 1'b0;
          s_d.slot  = 3'h0;
          s_d.seg   = i_mode64 ? i_segment_identifier
                               : {33'h0_0000_0000, i_segment_identifier[18:0]};
          s_d.abbreviated_page_index   = i_abbreviated_page_index;
          s_d.org   = i_table_origin;
          s_d.msk   = req_msk;
          s_d.hash  = req_hash;
          s_d.addr  = slot_addr(i_mode64, req_hash, i_table_origin,
                                req_msk, 3'h0);
          s_d.hit   = 1'b0;
          s_d.fault = 1'b0;
        end
      end
      hptag_pkg::PH_FETCH: begin
        if (i_mem_ack) begin
          if (ent_match) begin
            // resident page: report the matching entry
            s_d.phase    = hptag_pkg::PH_IDLE;
            s_d.done     = 1'b1;
            s_d.hit      = 1'b1;
            s_d.ent_addr = s_q.addr;
          end else if (s_q.slot != `HPTAG_LAST_SLOT) begin
            // next of the eight slots in this group [R4]
            s_d.slot = s_q.slot + 3'h1;
            s_d.addr = slot_addr(s_q.m64, cur_hash, s_q.org, s_q.msk,
                                 s_q.slot + 3'h1);
          end else if (!s_q.sec) begin
            // primary group exhausted: switch to secondary [R5] [R10]
            s_d.sec  = 1'b1;
            s_d.slot = 3'h0;
            s_d.addr = slot_addr(s_q.m64, ~s_q.hash, s_q.org, s_q.msk,
                                 3'h0);
          end else begin
            // no third group exists, so this is a page fault [R6] [R4]
            s_d.phase = hptag_pkg::PH_IDLE;
            s_d.done  = 1'b1;
            s_d.fault = 1'b1;
          end
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign o_req_ready  = (s_q.phase == hptag_pkg::PH_IDLE);
  assign o_mem_req    = (s_q.phase == hptag_pkg::PH_FETCH);
  assign o_mem_addr   = s_q.addr;
  assign o_done       = s_q.done;
  assign o_hit        = s_q.hit;
  assign o_page_fault = s_q.fault;
  assign o_entry_addr = s_q.ent_addr;

  // reads issued in the current search, for the bound check
  logic [4:0] reads_q;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      reads_q <= 5'h00;
    end else if (o_req_ready) begin
      reads_q <= 5'h00;
    end else if (i_mem_ack) begin
      reads_q <= reads_q + 5'h01;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  AST_STRIDE64: assert property ( // [R1]
    o_mem_req && s_q.m64 |-> o_mem_addr[6:4] == s_q.slot &&
                             o_mem_addr[3:0] == 4'h0)
    else $error("64-bit entry address not on 16-byte slot");
  AST_GROUP32: assert property ( // [R2]
    o_mem_req && !s_q.m64 |-> o_mem_addr[5:3] == s_q.slot &&
                              o_mem_addr[2:0] == 3'h0 &&
                              o_mem_addr[63:32] == 32'h0000_0000)
    else $error("32-bit entry address outside 64-byte group");
  AST_TWO_GROUPS: assert property ( // [R4]
    o_mem_req |-> reads_q < 5'h10)
    else $error("more than sixteen entries read in one search");
  AST_PRIMARY_FIRST: assert property ( // [R5]
    o_req_ready && i_req_valid |=> o_mem_req && !s_q.sec && s_q.slot == 3'h0)
    else $error("search did not open on primary slot 0");
  AST_FAULT: assert property ( // [R6]
    $rose(o_page_fault) |-> $past(s_q.sec) && $past(s_q.slot) == 3'h7 &&
                            !o_hit && o_done)
    else $error("page fault without exhausted secondary group");
  AST_HASH64: assert property ( // [R9]
    o_req_ready && i_req_valid && i_mode64 |=>
      s_q.hash == ($past(i_segment_identifier[38:0]) ^
                   {23'h00_0000, $past(i_page_index)}))
    else $error("64-bit primary hash wrong");
  AST_HASH32: assert property ( // [R11]
    o_req_ready && i_req_valid && !i_mode64 |=>
      s_q.hash[18:0] == ($past(i_segment_identifier[18:0]) ^
                         {3'h0, $past(i_page_index)}))
    else $error("32-bit primary hash wrong");
  AST_LOW_HASH: assert property ( // [R10]
    o_mem_req && s_q.m64 |-> o_mem_addr[17:7] ==
                             (s_q.sec ? ~s_q.hash[10:0] : s_q.hash[10:0]))
    else $error("64-bit low hash bits wrong in group address");
  AST_LAYOUT32: assert property ( // [R13]
    o_mem_req && !s_q.m64 |-> o_mem_addr[15:6] ==
      (s_q.sec ? ~s_q.hash[9:0] : s_q.hash[9:0]) &&
      o_mem_addr[31:25] == s_q.org[15:9])
    else $error("32-bit group address layout wrong");
  AST_MASK64: assert property ( // [R16] [R14] [R8]
    o_mem_req && s_q.m64 |-> o_mem_addr[45:18] ==
      (s_q.org[27:0] | ((s_q.sec ? ~s_q.hash[38:11] : s_q.hash[38:11]) &
                        s_q.msk)) && o_mem_addr[63:46] == s_q.org[45:28])
    else $error("64-bit masked origin bits wrong");
  AST_HIT: assert property ( // [R15]
    $rose(o_hit) |-> $past(i_ent_valid) &&
                     $past(i_ent_hash_sel) == $past(s_q.sec) &&
                     $past(i_ent_segment_identifier) == $past(s_q.seg) &&
                     $past(i_ent_abbreviated_page_index) == $past(s_q.abbreviated_page_index) &&
                     o_entry_addr == $past(o_mem_addr))
    else $error("hit reported for an entry that does not match");

  COV_PRIMARY_HIT: cover property (o_done && o_hit && !s_q.sec);
  COV_SECONDARY_HIT: cover property (o_done && o_hit && s_q.sec);
  COV_FAULT: cover property (o_done && o_page_fault);
  COV_BOTH_MODES: cover property (o_mem_req && s_q.m64 ##[1:40] !s_q.m64);

endmodule // hptag_top
`default_nettype wire

// ===== verif/hashed_page_table_address_gen_tb.sv
// self-checking bench of the hashed page table search front end
`timescale 1ns/100ps
`default_nettype none
module hashed_page_table_address_gen_tb;
  logic i_clock = 1'b0, i_sys_rst = 1'b1, req = 1'b0, m64 = 1'b0;
  logic hs = 1'b0, hv = 1'b0, ack, ev, es, rdy, mreq, done, hit, pf;
  logic [51:0] seg = 52'h0, eseg;  // request and returned identifiers
  logic [15:0] page = 16'h0;
  logic [5:0] abbreviated_page_index = 6'h0, eapi;
  logic [45:0] org = 46'h0;
  logic [8:0] m9 = 9'h0;
  logic [4:0] code = 5'h0;
  logic [3:0] lat = 4'h0;          // memory wait cycles per read
  logic [63:0] maddr, eaddr, haddr = 64'h0;
  logic [63:0] log_q [16];         // entry addresses in read order
  int acks = 0, miscompares = 0, comparisons = 0;

  hptag_top i_hptag_top (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_req_valid(req), .o_req_ready(rdy), .i_mode64(m64),
    .i_segment_identifier(seg), .i_page_index(page),
    .i_abbreviated_page_index(abbreviated_page_index), .i_table_origin(org),
    .i_table_index_mask(m9), .i_table_size_code(code), .o_mem_req(mreq),
    .o_mem_addr(maddr), .i_mem_ack(ack), .i_ent_valid(ev),
    .i_ent_hash_sel(es), .i_ent_segment_identifier(eseg),
    .i_ent_abbreviated_page_index(eapi), .o_done(done), .o_hit(hit),
    .o_page_fault(pf), .o_entry_addr(eaddr));
  hptag_mem_model i_hptag_mem_model (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_mem_req(mreq), .i_mem_addr(maddr),
    .o_mem_ack(ack), .o_ent_valid(ev), .o_ent_hash_sel(es),
    .o_ent_seg(eseg), .o_ent_api(eapi), .i_hit_addr(haddr),
    .i_hit_valid(hv), .i_hit_sel(hs), .i_seg(seg), .i_api(abbreviated_page_index),
    .i_lat(lat));

  // 50 MHz clock
  initial begin
    forever #10 i_clock = ~i_clock;
  end

  // log every accepted read so the walk order can be judged
  always @(posedge i_clock) begin
    if (mreq && ack && acks < 16) log_q[acks] <= maddr;
    if (mreq && ack) acks <= acks + 1;
  end

  // expected hash; the secondary is the complement of the primary
  function automatic logic [38:0] hash(input logic sec);
    logic [38:0] h;
    h = m64 ? seg[38:0] ^ {23'h0, page} : {20'h0, seg[18:0] ^ {3'h0, page}};
    if (sec) h = m64 ? ~h : {20'h0, ~h[18:0]};
    return h;
  endfunction

  // expected group address from origin and the masked upper hash
  function automatic logic [63:0] grp(input logic sec);
    logic [38:0] h;
    logic [27:0] m28;
    h = hash(sec);
    // codes above 28 saturate to a mask of all ones
    m28 = (code > 5'h1C) ? 28'hFFF_FFFF : (28'h1 << code) - 28'h1;
    if (m64) return {org[45:28], org[27:0] | (h[38:11] & m28), h[10:0], 7'h0};
    return {32'h0, org[15:9], org[8:0] | (h[18:10] & m9), h[9:0], 6'h0};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one search: request held for one clock edge, then a bounded wait for done
  task automatic run();
    acks = 0;
    req = 1'b1;
    @(posedge i_clock);
    @(negedge i_clock);
    req = 1'b0;
    chk(rdy, 1'b0);  // busy: a second request would be refused
    for (int n = 0; n < 300 && done !== 1'b1; n++) @(negedge i_clock);
    chk(done, 1'b1);
    chk(rdy, 1'b1);
  endtask

  // 64-bit, 2^15 groups, hit in primary slot 3, fast memory
  task automatic t_hit64();
    m64 = 1'b1;
    seg = 52'h1_2345_6789_ABCD;
    page = 16'hBEEF;
    abbreviated_page_index = 6'h2A;
    code = 5'h4;
    org = 46'h12_3456_7890;  // low four origin bits clear under the mask
    lat = 4'h0;
    haddr = grp(1'b0) + 64'h30;
    hs = 1'b0;
    hv = 1'b1;
    run();
    chk(hit, 1'b1);
    chk(pf, 1'b0);
    chk(eaddr, haddr);
    chk(acks, 4);
    chk(log_q[0], grp(1'b0));
  endtask

  // 32-bit, 128 Kbyte table, hit in secondary slot 7, slow memory
  task automatic t_sec32();
    m64 = 1'b0;
    seg = 52'h5_A5A5;
    page = 16'h1234;
    m9 = 9'h001;
    org = 46'hABCE;  // lowest maskable origin bit is zero
    lat = 4'h2;
    haddr = grp(1'b1) + 64'h38;
    hs = 1'b1;
    run();
    chk(hit, 1'b1);
    chk(eaddr, haddr);
    chk(log_q[7], grp(1'b0) + 64'h38);
    chk(log_q[8], grp(1'b1));
  endtask

  // 64-bit, matching entry in the primary group but hash select set
  task automatic t_wrong_sel();
    m64 = 1'b1;
    code = 5'h1D;  // out-of-range code: full 28-bit mask
    org = 46'h3F_F000_0000;  // origin bits under the full mask clear
    lat = 4'h0;
    haddr = grp(1'b0);
    hs = 1'b1;
    run();
    chk(pf, 1'b1);
    chk(hit, 1'b0);
    chk(acks, 16);
    chk(log_q[15], grp(1'b1) + 64'h70);
  endtask

  // 32-bit, 64 Kbyte minimum table, secondary entry not valid
  task automatic t_invalid();
    m64 = 1'b0;
    m9 = 9'h000;  // smallest table, sized by software
    haddr = grp(1'b1) + 64'h8;
    hv = 1'b0;
    run();
    chk(pf, 1'b1);
    chk(log_q[8], grp(1'b1));
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // reset for eight cycles, then the scenarios
  initial begin
    repeat (8) @(negedge i_clock);
    i_sys_rst = 1'b0;
    t_hit64();
    t_sec32();
    t_wrong_sel();
    t_invalid();
    end_of_test();
  end

  // watchdog: four searches need far fewer than 5000 cycles
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule // hashed_page_table_address_gen_tb
`default_nettype wire

// ===== verif/hptag_mem_model.sv
// behavioural main memory holding one software-built table entry
`timescale 1ns/100ps
`default_nettype none
module hptag_mem_model (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // entry read port of the search block
  input  wire logic        i_mem_req,
  input  wire logic [63:0] i_mem_addr,
  output logic             o_mem_ack,
  output logic             o_ent_valid,
  output logic             o_ent_hash_sel,
  output logic [51:0]      o_ent_seg,
  output logic [5:0]       o_ent_api,
  // table content and pace, set by the bench
  input  wire logic [63:0] i_hit_addr,
  input  wire logic        i_hit_valid,
  input  wire logic        i_hit_sel,
  input  wire logic [51:0] i_seg,
  input  wire logic [5:0]  i_api,
  input  wire logic [3:0]  i_lat
);
  logic [3:0] wait_q;  // idle cycles spent on the current read

  // one ack per read after i_lat idle cycles
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wait_q         <= 4'h0;
      o_mem_ack      <= 1'b0;
      o_ent_valid    <= 1'b0;
      o_ent_hash_sel <= 1'b0;
      o_ent_seg      <= 52'h0;
      o_ent_api      <= 6'h0;
    end else if (!i_mem_req || o_mem_ack) begin
      // fields flip between acks so a stale value never stays steady
      wait_q         <= 4'h0;
      o_mem_ack      <= 1'b0;
      o_ent_valid    <= ~o_ent_valid;
      o_ent_hash_sel <= ~o_ent_hash_sel;
      o_ent_seg      <= ~o_ent_seg;
      o_ent_api      <= ~o_ent_api;
    end else if (wait_q == i_lat) begin
      o_mem_ack <= 1'b1;
      if (i_mem_addr == i_hit_addr) begin  // entry placed by the hash
        o_ent_valid    <= i_hit_valid;
        o_ent_hash_sel <= i_hit_sel;
        o_ent_seg      <= i_seg;
        o_ent_api      <= i_api;
      end else begin  // other slots: valid, hash select from i_hit_sel, identifier or abbreviated page index wrong
        o_ent_valid    <= 1'b1;
        o_ent_hash_sel <= i_hit_sel;
        // address bit 5 picks whether the identifier or abbreviated page index differs
        o_ent_seg      <= i_mem_addr[5] ? ~i_seg : i_seg;
        o_ent_api      <= i_mem_addr[5] ? i_api : ~i_api;
      end
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // hptag_mem_model
`default_nettype wire
